// ===== src/bdi_pkg.sv
// Purpose: Shared constants and types for the bus driver digital interface.
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package bdi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RX_MIN_BIT_NS = 60;
  // Half the shortest bit, rounded down, so a 60 ns bit is still seen.
  localparam int RX_FILTER_CYC = RX_MIN_BIT_NS / CLK_PERIOD_NS / 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields and reset values.
  localparam int CTRL_TX_INHIBIT_BIT = 0;
  localparam logic CTRL_TX_INHIBIT_RESET = 1'h0;

  // Status register field positions.
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_TX_ON_BIT = 5;
  localparam int STAT_SYM_LSB = 6;
  localparam int STAT_OTEMP_BIT = 8;
  localparam int STAT_VIO_BIT = 9;
  localparam int STAT_WAKE_BIT = 10;

  // Interrupt bits, shared by status, clear and enable registers.
  localparam int IRQ_W = 4;
  localparam int IRQ_MODE_BIT = 0;
  localparam int IRQ_OTEMP_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int IRQ_VIO_BIT = 3;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BDI_NORMAL = 5'h01,
    BDI_LISTEN = 5'h02,
    BDI_STANDBY = 5'h04,
    BDI_SLEEP_ENTRY = 5'h08,
    BDI_SLEEP = 5'h10
  } bdi_mode_t;

  typedef enum logic [1:0] {
    BDI_SYM_IDLE = 2'h0,
    BDI_SYM_ZERO = 2'h1,
    BDI_SYM_ONE = 2'h2
  } bdi_sym_t;

  // Pin-side inputs, all asynchronous to the clock.
  typedef struct packed {
    logic powered;
    logic io_supply_ok;
    logic standby_n_select;
    logic mode_enable;
    logic transmit_enable_n;
    logic serial_transmit_in;
    logic guardian_enable;
    logic overtemp;
    logic wake_flag;
    logic bus_diff_pos;
    logic bus_diff_neg;
  } bdi_pins_t;

endpackage

// ===== src/bdi_core.sv
// Purpose: Digital side of a differential bus transceiver.
// Assumes: Analog comparators report the bus symbol as two levels.
// Notes: All pin inputs pass a two-stage synchroniser first.
`timescale 1ns/10ps

// Behaviour
// - Transmitter drives bus only in normal mode.
// - Transmit needs normal, enable low, guardian high.
// - Activation accepted only while transmit data low.
// - Enabled transmitter follows data: one or zero.
// - Guardian low forces transmitter off, bus idle.
// - Guardian input evaluated only in normal mode.
// - Receiver active in normal and listen modes.
// - Receive out high for one/idle, low zero.
// - Activity out high idle, low on data.
// - Low-power modes ignore transmit data and enable.
// - Low-power outputs show wake flag, low when set.
// - Bias in active modes, ground low-power, open unpowered.
// - Supply loss: receive low, transmit inputs defaulted.
// - Supply loss: activity low, guardian defaulted.
// - Receive filter keeps bits down to 60 ns.
// - Activity to guardian side, data to controller.
// - Input defaults: data low, enable high, others low.
// - Mode select pins decode four modes, sleep entry.
module bdi_core
  import bdi_pkg::*;
#(
  parameter int RX_FILTER = RX_FILTER_CYC
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_powered,
  input wire logic i_io_supply_ok,
  input wire logic i_standby_n_select,
  input wire logic i_mode_enable,
  input wire logic i_transmit_enable_n,
  input wire logic i_serial_transmit_in,
  input wire logic i_guardian_enable,
  input wire logic i_overtemp,
  input wire logic i_wake_flag,
  input wire logic i_bus_diff_pos,
  input wire logic i_bus_diff_neg,
  output logic o_drive_enable,
  output logic o_drive_one,
  output logic o_serial_receive_out,
  output logic o_bus_activity_n,
  output logic o_bias_to_vbias,
  output logic o_bias_to_ground,
  output logic o_irq,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // The whole block state lives in one register, so that one reset clause
  // and one update cover every flip-flop, including both synchroniser
  // stages of the pin inputs.
  typedef struct packed {
    bdi_pins_t s1;
    bdi_pins_t s2;
    bdi_sym_t cand;
    logic [3:0] cnt;
    bdi_sym_t sym;
    bdi_mode_t mode;
    logic tx_on;
    logic tx_one;
    logic rxd;
    logic bus_activity_n_n;
    logic bias_v;
    logic bias_g;
    logic inhibit;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic prev_ot;
    logic prev_wake;
    logic prev_vio;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bdi_state_t;

  bdi_state_t r;
  bdi_state_t next_r;
  bdi_pins_t pins;
  bdi_pins_t p;
  bdi_sym_t seen;
  logic low_power;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] ev;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Word address of a byte address, low two bits ignored.
  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = {a[ADDR_W-1:2], 2'h0};
  endfunction

  // Whether an address hits one of the five registers.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = word_of(a);
    mapped = (w == ADDR_CTRL) || (w == ADDR_STATUS) ||
      (w == ADDR_IRQ_STATUS) || (w == ADDR_IRQ_CLEAR) ||
      (w == ADDR_IRQ_ENABLE);
  endfunction

  // Read data for a register; write-only and unmapped read zero.
  // Status reads see the synchronised pins, never the raw inputs.
  function automatic logic [31:0] read_word(input bdi_state_t s,
    input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (word_of(a))
      ADDR_CTRL: d[CTRL_TX_INHIBIT_BIT] = s.inhibit;
      ADDR_STATUS:
      begin
        d[STAT_MODE_LSB +: 5] = s.mode;
        d[STAT_TX_ON_BIT] = s.tx_on;
        d[STAT_SYM_LSB +: 2] = s.sym;
        d[STAT_OTEMP_BIT] = s.s2.overtemp;
        d[STAT_VIO_BIT] = s.s2.io_supply_ok;
        d[STAT_WAKE_BIT] = s.s2.wake_flag;
      end
      ADDR_IRQ_STATUS: d[IRQ_W-1:0] = s.ist;
      ADDR_IRQ_ENABLE: d[IRQ_W-1:0] = s.ien;
      default: d = 32'h0;
    endcase
    read_word = d;
  endfunction

  // Gather the pins for the synchroniser.
  // One packed word keeps both stages in step, field for field.
  assign pins = '{powered: i_powered, io_supply_ok: i_io_supply_ok,
    standby_n_select: i_standby_n_select, mode_enable: i_mode_enable,
    transmit_enable_n: i_transmit_enable_n,
    serial_transmit_in: i_serial_transmit_in,
    guardian_enable: i_guardian_enable, overtemp: i_overtemp,
    wake_flag: i_wake_flag, bus_diff_pos: i_bus_diff_pos,
    bus_diff_neg: i_bus_diff_neg};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One pass computes every next value of the state.
  always_comb
  begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    clr = '0;

    // defaulted inputs while the supply is lost.
    p = r.s2;
    if (!p.io_supply_ok)
    begin
      p.serial_transmit_in = 1'b0;
      p.transmit_enable_n = 1'b1;
      p.guardian_enable = 1'b0;
      p.standby_n_select = 1'b0;
      p.mode_enable = 1'b0;
    end

    // mode pins decode; sleep entry moves on to sleep.
    // Supply loss has already forced both mode pins low, hence standby.
    unique case ({p.standby_n_select, p.mode_enable})
      2'b11: next_r.mode = BDI_NORMAL;
      2'b10: next_r.mode = BDI_LISTEN;
      2'b01:
      begin
        if (r.mode == BDI_SLEEP_ENTRY || r.mode == BDI_SLEEP)
          next_r.mode = BDI_SLEEP;
        else
          next_r.mode = BDI_SLEEP_ENTRY;
      end
      default: next_r.mode = BDI_STANDBY;
    endcase
    low_power = !(r.mode == BDI_NORMAL || r.mode == BDI_LISTEN);

    // enable only in normal mode with both inputs.
    // guardian low or overheating force the driver off.
    // a new activation needs transmit data low.
    // Once on, the driver follows the data until an enable term drops,
    // so a transmission can never begin with a one on the bus.
    next_r.tx_on = (r.mode == BDI_NORMAL) && !p.transmit_enable_n &&
      p.guardian_enable && !p.overtemp && !r.inhibit &&
      (r.tx_on || !p.serial_transmit_in);
    // drive level follows the serial data.
    next_r.tx_one = next_r.tx_on && p.serial_transmit_in;

    // a symbol counts once stable for the filter time.
    // A glitch shorter than the filter span never reaches the outputs,
    // while the shortest legal bit still does.
    if (p.bus_diff_pos && !p.bus_diff_neg)
      seen = BDI_SYM_ONE;
    else if (p.bus_diff_neg && !p.bus_diff_pos)
      seen = BDI_SYM_ZERO;
    else
      seen = BDI_SYM_IDLE;
    if (seen != r.cand)
    begin
      next_r.cand = seen;
      next_r.cnt = 4'h0;
    end
    else if (r.cnt < 4'(RX_FILTER - 1))
      next_r.cnt = r.cnt + 4'h1;
    else
      next_r.sym = seen;

    // receive and activity outputs per mode.
    if (!p.io_supply_ok)
    begin
      // both outputs low on supply loss.
      next_r.rxd = 1'b0;
      next_r.bus_activity_n_n = 1'b0;
    end
    else if (low_power)
    begin
      next_r.rxd = !p.wake_flag;
      next_r.bus_activity_n_n = !p.wake_flag;
    end
    else
    begin
      next_r.rxd = (r.sym != BDI_SYM_ZERO);
      next_r.bus_activity_n_n = (r.sym == BDI_SYM_IDLE);
    end

    // bias follows mode, open when unpowered.
    next_r.bias_v = p.powered && !low_power;
    next_r.bias_g = p.powered && low_power;

    // Write channel: address and data taken in either order.
    // The write lands one cycle after both are held, and the readies stay
    // low until the response has been taken.
    if (r.bvalid && i_bready)
      next_r.bvalid = 1'b0;
    if (r.awready && i_awvalid)
    begin
      next_r.aw_got = 1'b1;
      next_r.waddr = i_awaddr;
    end
    if (r.wready && i_wvalid)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = i_wdata;
      next_r.wstrb = i_wstrb;
    end
    if (r.aw_got && r.w_got)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (r.wstrb[0])
      begin
        if (word_of(r.waddr) == ADDR_CTRL)
          next_r.inhibit = r.wdata[CTRL_TX_INHIBIT_BIT];
        if (word_of(r.waddr) == ADDR_IRQ_ENABLE)
          next_r.ien = r.wdata[IRQ_W-1:0];
        if (word_of(r.waddr) == ADDR_IRQ_CLEAR)
          clr = r.wdata[IRQ_W-1:0];
      end
    end
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;

    // Read channel: one read at a time, answered the next cycle.
    if (r.rvalid && i_rready)
      next_r.rvalid = 1'b0;
    if (r.arready && i_arvalid)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = read_word(r, i_araddr);
      next_r.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_r.arready = !next_r.rvalid;

    // Sticky events; a new event wins over a clear.
    // The mode event compares next and current mode, so the way into
    // sleep through sleep entry raises it on both steps.
    ev = '0;
    ev[IRQ_MODE_BIT] = (next_r.mode != r.mode);
    ev[IRQ_OTEMP_BIT] = p.overtemp && !r.prev_ot;
    ev[IRQ_WAKE_BIT] = r.s2.wake_flag && !r.prev_wake;
    ev[IRQ_VIO_BIT] = !r.s2.io_supply_ok && r.prev_vio;
    next_r.prev_ot = p.overtemp;
    next_r.prev_wake = r.s2.wake_flag;
    next_r.prev_vio = r.s2.io_supply_ok;
    next_r.ist = (r.ist & ~clr) | ev;
    next_r.irq = |(next_r.ist & next_r.ien);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Synchronous reset puts the block in standby with the bus idle.
  // Synchroniser stages reset to idle pin levels, so that no false edge
  // or supply-loss event follows the release of reset.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      r <= '0;
      r.s1.transmit_enable_n <= 1'b1;
      r.s2.transmit_enable_n <= 1'b1;
      r.s1.io_supply_ok <= 1'b1;
      r.s2.io_supply_ok <= 1'b1;
      r.prev_vio <= 1'b1;
      r.mode <= BDI_STANDBY;
      r.cand <= BDI_SYM_IDLE;
      r.sym <= BDI_SYM_IDLE;
      r.rxd <= 1'b1;
      r.bus_activity_n_n <= 1'b1;
      r.inhibit <= CTRL_TX_INHIBIT_RESET;
      r.ien <= IRQ_ENABLE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output is a field of the state register.
  assign o_drive_enable = r.tx_on;
  assign o_drive_one = r.tx_one;
  assign o_serial_receive_out = r.rxd;
  assign o_bus_activity_n = r.bus_activity_n_n;
  assign o_bias_to_vbias = r.bias_v;
  assign o_bias_to_ground = r.bias_g;
  assign o_irq = r.irq;
  assign o_awready = r.awready;
  assign o_wready = r.wready;
  assign o_bvalid = r.bvalid;
  assign o_bresp = r.bresp;
  assign o_arready = r.arready;
  assign o_rvalid = r.rvalid;
  assign o_rdata = r.rdata;
  assign o_rresp = r.rresp;

endmodule

// ===== bench/bdi_bus_model.sv
// Purpose: Behavioural model of the two-wire bus seen by the comparators.
// Assumes: A driving transmitter wins over any remote node.
// Notes: A released bus shows idle, which both comparators read low.
`timescale 1ns/10ps
module bdi_bus_model
  import bdi_pkg::*;
(
  input wire logic i_drive_enable,
  input wire logic i_drive_one,
  input wire bdi_sym_t i_remote,
  output logic o_pos,
  output logic o_neg
);
  // own symbol on bus
  // The local driver sets the symbol, else the remote node does.
  always_comb
  begin
    o_pos = i_drive_enable ? i_drive_one : (i_remote == BDI_SYM_ONE);
    o_neg = i_drive_enable ? !i_drive_one : (i_remote == BDI_SYM_ZERO);
  end
endmodule

// ===== bench/bdi_core_properties.sv
// Purpose: Port-level checks on the bus driver digital interface.
// Assumes: Pins settle through the synchroniser within a few cycles.
// Notes: Hold spans allow for two sync flops and output registers.
`timescale 1ns/10ps
module bdi_core_props
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_powered,
  input wire logic i_io_supply_ok,
  input wire logic i_standby_n_select,
  input wire logic i_transmit_enable_n,
  input wire logic i_guardian_enable,
  input wire logic i_overtemp,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_drive_enable,
  input wire logic o_drive_one,
  input wire logic o_serial_receive_out,
  input wire logic o_bus_activity_n,
  input wire logic o_bias_to_vbias,
  input wire logic o_bias_to_ground,
  input wire logic o_irq,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // Assertions tie the drive, receive and bias outputs to the pins that govern them, and check that bus responses hold.
  a_start_low: assert property (
    $rose(o_drive_enable) |-> !o_drive_one) else $error("start on one");
  a_guard_off: assert property (
    (!i_guardian_enable)[*6] |-> !o_drive_enable) else $error("guard");
  a_enable_off: assert property (
    i_transmit_enable_n[*6] |-> !o_drive_enable) else $error("enable");
  a_heat_off: assert property (
    i_overtemp[*6] |-> !o_drive_enable) else $error("overtemp");
  a_lowpwr_idle: assert property (
    (!i_standby_n_select)[*8] |-> !o_drive_enable) else $error("lowpwr");
  a_vio_loss: assert property (
    (i_powered && !i_io_supply_ok)[*6] |->
    !o_serial_receive_out && !o_bus_activity_n) else $error("vio");
  a_bias_open: assert property (
    (!i_powered)[*6] |-> !o_bias_to_vbias && !o_bias_to_ground)
    else $error("bias not open");
  a_bias_excl: assert property (
    o_bias_to_vbias |-> !o_bias_to_ground) else $error("bias both");
  a_one_needs_on: assert property (
    o_drive_one |-> o_drive_enable) else $error("one while off");
  a_bresp_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("bresp dropped");
  a_rdata_hold: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("rdata dropped");

  // Covers show the main scenarios were reached.
  c_tx_on: cover property ($rose(o_drive_enable));
  c_irq: cover property ($rose(o_irq));
  c_rx_zero: cover property (!o_serial_receive_out && !o_bus_activity_n);
endmodule

bind bdi_core bdi_core_props bdi_core_props_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_powered(i_powered),
  .i_io_supply_ok(i_io_supply_ok), .i_standby_n_select(i_standby_n_select),
  .i_transmit_enable_n(i_transmit_enable_n),
  .i_guardian_enable(i_guardian_enable), .i_overtemp(i_overtemp),
  .i_bready(i_bready), .i_rready(i_rready),
  .o_drive_enable(o_drive_enable), .o_drive_one(o_drive_one),
  .o_serial_receive_out(o_serial_receive_out),
  .o_bus_activity_n(o_bus_activity_n), .o_bias_to_vbias(o_bias_to_vbias),
  .o_bias_to_ground(o_bias_to_ground), .o_irq(o_irq), .o_bvalid(o_bvalid),
  .o_bresp(o_bresp), .o_rvalid(o_rvalid), .o_rdata(o_rdata));

// ===== bench/tb.sv
// Purpose: Self-checking bench for the bus driver digital interface.
// Assumes: Fixed seed; pins held long enough to pass sync and filter.
// Notes: Register access goes through small bus tasks.
`timescale 1ns/10ps
module tb;
  import bdi_pkg::*;
  logic i_clock, i_reset, awvalid, wvalid, bready, arvalid, rready;
  logic pos, neg, de, d1, rxd, act, bv, bg, irq, awr, wr, bval, arr, rval;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d, rdata, rnd_state;
  logic [3:0] wstrb;
  logic [1:0] r, bresp, rresp;
  bdi_sym_t remote;
  bdi_pins_t p;
  int err_total, checks_done, m;

  bdi_core bdi_core_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_powered(p.powered), .i_io_supply_ok(p.io_supply_ok),
    .i_standby_n_select(p.standby_n_select), .i_mode_enable(p.mode_enable),
    .i_transmit_enable_n(p.transmit_enable_n),
    .i_serial_transmit_in(p.serial_transmit_in),
    .i_guardian_enable(p.guardian_enable), .i_overtemp(p.overtemp),
    .i_wake_flag(p.wake_flag), .i_bus_diff_pos(pos), .i_bus_diff_neg(neg),
    .o_drive_enable(de), .o_drive_one(d1), .o_serial_receive_out(rxd),
    .o_bus_activity_n(act), .o_bias_to_vbias(bv), .o_bias_to_ground(bg),
    .o_irq(irq), .i_awvalid(awvalid), .o_awready(awr), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wr), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bval), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arr), .i_araddr(araddr),
    .o_rvalid(rval), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
  bdi_bus_model bdi_bus_model_inst (.i_drive_enable(de), .i_drive_one(d1),
    .i_remote(remote), .o_pos(pos), .o_neg(neg));

  // Free-running 100 MHz clock.
  initial
  begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end

  // Watchdog cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    final_report();
  end

  task final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask

  task settle();
    repeat (12) @(posedge i_clock);
  endtask

  // Write one word; each channel is released when it is taken.
  task axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge i_clock);
      n++;
      if (awvalid && awr)
        awvalid <= 1'h0;
      if (wvalid && wr)
        wvalid <= 1'h0;
    end while (!bval && n < 50);
    r = bresp;
    bready <= 1'h0;
    err_total += (n >= 50);
    @(posedge i_clock);
  endtask

  // Read one word into d and its response into r.
  task axr(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge i_clock);
      n++;
      if (arvalid && arr)
        arvalid <= 1'h0;
    end while (!rval && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    err_total += (n >= 50);
    @(posedge i_clock);
  endtask

  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction

  function automatic logic [4:0] exp_mode(input int k);
    return k == 0 ? 5'h04 : k == 1 ? 5'h10 : k == 2 ? 5'h02 : 5'h01;
  endfunction

  function automatic logic [1:0] exp_rx(input bdi_sym_t s);
    return s == BDI_SYM_ZERO ? 2'h0 : s == BDI_SYM_ONE ? 2'h2 : 2'h3;
  endfunction

  // Main sequence of scenarios.
  initial
  begin
    {err_total, checks_done, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    rnd_state = 32'h435fa2c7;
    i_reset = 1'h1;
    wstrb = 4'hf;
    remote = BDI_SYM_IDLE;
    p = '{powered: 1'h1, io_supply_ok: 1'h1, default: 1'h0};
    p.transmit_enable_n = 1'h1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'h0;
    repeat (3) @(posedge i_clock);
    axr(ADDR_CTRL);
    chk(d, 32'h0);
    axr(8'h3c);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    for (m = 0; m < 4; m++)
    begin
      p.standby_n_select <= m[1];
      p.mode_enable <= m[0];
      p.transmit_enable_n <= 1'h0;
      p.guardian_enable <= 1'h1;
      settle();
      chk({bv, bg}, (m >= 2) ? 2'h2 : 2'h1);
      chk(de, m == 3);
      axr(ADDR_STATUS);
      chk(d[4:0], exp_mode(m));
    end
    for (m = 0; m < 24; m++)
    begin
      p.serial_transmit_in <= 1'(rnd());
      settle();
      chk({d1, rxd, act}, {{2{p.serial_transmit_in}}, 1'h0});
    end
    p.transmit_enable_n <= 1'h1;
    p.serial_transmit_in <= 1'h1;
    settle();
    chk({de, rxd, act}, 3'h3);
    p.transmit_enable_n <= 1'h0;
    settle();
    chk(de, 1'h0);
    p.serial_transmit_in <= 1'h0;
    settle();
    chk(de, 1'h1);
    p.guardian_enable <= 1'h0;
    settle();
    chk(de, 1'h0);
    p.guardian_enable <= 1'h1;
    axw(ADDR_IRQ_ENABLE, 32'h1 << IRQ_OTEMP_BIT);
    axw(ADDR_IRQ_CLEAR, 32'hf);
    p.overtemp <= 1'h1;
    settle();
    chk({de, irq}, 2'h1);
    p.overtemp <= 1'h0;
    axw(ADDR_IRQ_CLEAR, 32'hf);
    settle();
    chk({de, irq}, 2'h2);
    axw(ADDR_IRQ_ENABLE, 32'h0);
    wstrb <= 4'h0;
    axw(ADDR_CTRL, 32'h1);
    wstrb <= 4'hf;
    p.overtemp <= 1'h1;
    settle();
    p.overtemp <= 1'h0;
    axr(ADDR_IRQ_STATUS);
    chk({irq, d[IRQ_OTEMP_BIT]}, 2'h1);
    settle();
    chk(de, 1'h1);
    axw(ADDR_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    settle();
    chk(de, 1'h0);
    axw(8'h3c, 32'h1);
    chk(r, RESP_SLVERR);
    p.mode_enable <= 1'h0;
    for (m = 0; m < 3; m++)
    begin
      remote <= bdi_sym_t'(2 - m);
      settle();
      chk({rxd, act}, exp_rx(bdi_sym_t'(2 - m)));
    end
    // a two-cycle glitch, shorter than a bit, is filtered out.
    remote <= BDI_SYM_ZERO;
    repeat (2) @(posedge i_clock);
    remote <= BDI_SYM_IDLE;
    repeat (8)
    begin
      @(posedge i_clock);
      chk({rxd, act}, 2'h3);
    end
    p.standby_n_select <= 1'h0;
    remote <= BDI_SYM_ZERO;
    for (m = 0; m < 2; m++)
    begin
      p.wake_flag <= m[0];
      settle();
      chk({rxd, act}, m ? 2'h0 : 2'h3);
    end
    p.io_supply_ok <= 1'h0;
    settle();
    chk({rxd, act}, 2'h0);
    axr(ADDR_IRQ_STATUS);
    chk(d, 32'hf);
    p.powered <= 1'h0;
    settle();
    chk({bv, bg}, 2'h0);
    final_report();
  end
endmodule
